// ===== logic/uecc_ctrl.sv
// Endpoint, descriptor base and transceiver control registers over APB.
// Assumes a token engine beside it that reports token, NAK and result pulses.
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`include "uecc_defs.svh"
module uecc_ctrl #(
  parameter int NUM_EP = 16
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Token engine side
  input wire logic host_mode,
  input wire logic [3:0] tok_ep,
  input wire logic tok_nak,
  input wire logic tok_end,
  input wire logic tok_setup,
  input wire logic tok_in,
  // Endpoint answers for current token
  output logic ans_stall,
  output logic ans_accept,
  output logic ans_hshk,
  // Host control
  output logic host_retry,
  output logic host_pre_pid,
  output logic host_done,
  output uecc_pkg::uecc_pid_t desc_pid,
  output logic desc_pid_we,
  // Addressing and transceiver
  output logic [8:0] desc_base_hi_mask,
  output logic [7:0] desc_base_top,
  output logic xcvr_suspend,
  output logic weak_pulldown_enable,
  output logic clk48_use_alt,
  output logic clk48_settling
);
  import uecc_pkg::*;

  // ************************************************************
  // Registers
  // ************************************************************
  localparam uecc_pid_t NAK_PID = 4'hA;
  logic [7:0] base_top_r;
  logic [7:0] ep_r [NUM_EP];
  logic [7:0] xc_r;
  logic [7:0] done_cnt_r;
  logic [NUM_EP*8-1:0] ep_flat;
  logic [NUM_EP-1:0] rx_ok, tx_ok, setup_ok, stall, hshk;
  logic wr, rd, ep_hit, use_alt, settling;
  logic [3:0] ep_idx;
  uecc_hstate_e hstate_r;

  // Writes land at the end of the access phase, reads are captured at setup
  // so that prdata already stands while pready is high
  assign wr = psel & penable & pwrite & clk_en;
  assign rd = psel & ~penable & ~pwrite & clk_en;
  assign ep_hit = (paddr >= `UECC_OFS_EP_FIRST) && (paddr <= `UECC_OFS_EP_LAST)
    && (paddr[1:0] == 2'h0);
  assign ep_idx = paddr[5:2];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      base_top_r <= `UECC_BASE_RESET;
    end else if (wr && paddr == `UECC_OFS_BASE_TOP) begin
      base_top_r <= pwdata[7:0];
    end
  end

  // Bits 7 and 6 exist only in endpoint 0; reserved bits never store.
  // Masking at write time keeps reads and decode free of extra gating.
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++) begin : g_epreg
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          ep_r[g] <= `UECC_EP_RESET;
        end else if (wr && ep_hit && ep_idx == 4'(g)) begin
          ep_r[g] <= pwdata[7:0] & ((g == 0) ? `UECC_EP0_WMASK : `UECC_EPN_WMASK);
        end
      end
      assign ep_flat[g*8 +: 8] = ep_r[g];
    end
  endgenerate

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      xc_r <= `UECC_XC_RESET;
    end else if (wr && paddr == `UECC_OFS_XCVR_CTRL) begin
      xc_r <= pwdata[7:0] & `UECC_XC_WMASK;
    end
  end

  // ************************************************************
  // APB answer: zero wait, unmapped flagged as error
  // ************************************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~(ep_hit || paddr == `UECC_OFS_BASE_TOP
        || paddr == `UECC_OFS_XCVR_CTRL || paddr == `UECC_OFS_HOST_EVT);
      if (rd) begin
        if (ep_hit) begin
          prdata <= {24'h0, ep_r[ep_idx]};
        end else if (paddr == `UECC_OFS_BASE_TOP) begin
          prdata <= {24'h0, base_top_r};
        end else if (paddr == `UECC_OFS_XCVR_CTRL) begin
          prdata <= {24'h0, xc_r};
        end else if (paddr == `UECC_OFS_HOST_EVT) begin
          prdata <= {24'h0, done_cnt_r};
        end else begin
          prdata <= 32'h0;
        end
      end
    end
  end

  // ************************************************************
  // Endpoint decode
  // ************************************************************
  uecc_ep_decode #(.NUM_EP(NUM_EP)) u_dec (
    .ep_ctrl(ep_flat),
    .ep_rx_ok(rx_ok),
    .ep_tx_ok(tx_ok),
    .ep_setup_ok(setup_ok),
    .endpoint_halt(stall),
    .handshake_enable(hshk)
  );

  // ************************************************************
  // Token answers
  // ************************************************************
  // Host role reads endpoint 0 only, device role the addressed endpoint.
  // Answers lag the token by one cycle; the engine must wait for them.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ans_stall <= 1'b0;
      ans_accept <= 1'b0;
      ans_hshk <= 1'b0;
    end else if (clk_en) begin
      if (host_mode) begin
        ans_stall <= 1'b0;
        ans_accept <= 1'b1;
        ans_hshk <= ep_r[0][`UECC_HANDSHAKE_ENABLE];
      end else begin
        ans_stall <= stall[tok_ep];
        ans_accept <= tok_setup ? setup_ok[tok_ep]
          : (tok_in ? tx_ok[tok_ep] : rx_ok[tok_ep]);
        ans_hshk <= hshk[tok_ep];
      end
    end
  end

  // ************************************************************
  // Host NAK handling
  // ************************************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hstate_r <= UECC_H_IDLE;
      host_retry <= 1'b0;
      host_done <= 1'b0;
      desc_pid <= 4'h0;
      desc_pid_we <= 1'b0;
      done_cnt_r <= 8'h00;
    end else if (clk_en) begin
      host_retry <= 1'b0;
      host_done <= 1'b0;
      desc_pid_we <= 1'b0;
      case (hstate_r)
        UECC_H_IDLE: begin
          if (host_mode && tok_nak) begin
            if (ep_r[0][`UECC_EP_NAK_NAK_RETRY_DISABLE]) begin
              hstate_r <= UECC_H_DONE;
              desc_pid <= NAK_PID;
              desc_pid_we <= 1'b1;
            end else begin
              hstate_r <= UECC_H_RETRY;
            end
          end else if (host_mode && tok_end) begin
            host_done <= 1'b1;
            done_cnt_r <= done_cnt_r + 8'h01;
          end
        end
        UECC_H_RETRY: begin
          host_retry <= 1'b1;
          hstate_r <= UECC_H_IDLE;
        end
        UECC_H_DONE: begin
          host_done <= 1'b1;
          done_cnt_r <= done_cnt_r + 8'h01;
          hstate_r <= UECC_H_IDLE;
        end
        default: begin
          hstate_r <= UECC_H_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Addressing and transceiver outputs
  // ************************************************************
  // Source switch is tracked here; the clock mux itself sits outside the block
  uecc_clk_sel u_clk (
    .clock(clock),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .src_sel(xc_r[1:0]),
    .use_alt(use_alt),
    .settling(settling)
  );

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      desc_base_top <= `UECC_BASE_RESET;
      desc_base_hi_mask <= 9'h000;
      xcvr_suspend <= 1'b0;
      weak_pulldown_enable <= 1'b0;
      clk48_use_alt <= 1'b1;
      clk48_settling <= 1'b0;
      host_pre_pid <= 1'b0;
    end else if (clk_en) begin
      desc_base_top <= base_top_r;
      desc_base_hi_mask <= 9'h000;
      xcvr_suspend <= xc_r[`UECC_XC_SUSPEND];
      weak_pulldown_enable <= xc_r[`UECC_XC_PULLDOWN];
      clk48_use_alt <= use_alt;
      clk48_settling <= settling;
      host_pre_pid <= host_mode & ~ep_r[0][`UECC_EP_DIRECT_LS];
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  stall_over_a: assert property (clk_en && !host_mode && stall[tok_ep] ##1 clk_en
    |-> ans_stall) else $error("stall not answered");
  // A frozen cycle after the token would hold the old answer, so demand a live edge
  setup_rej_a: assert property (clk_en && !host_mode && tok_setup
    && ep_r[tok_ep][`UECC_EP_SETUP_DIS] ##1 clk_en |-> !ans_accept)
    else $error("setup accepted");
  setup_ok_a: assert property (clk_en && !host_mode && tok_setup && setup_ok[tok_ep]
    ##1 clk_en |-> ans_accept) else $error("setup refused");
  nak_done_a: assert property (clk_en && host_mode && tok_nak && hstate_r == UECC_H_IDLE
    && ep_r[0][`UECC_EP_NAK_NAK_RETRY_DISABLE] ##1 clk_en |=> host_done) else $error("no done");
  nak_pid_a: assert property (desc_pid_we |-> desc_pid == NAK_PID) else $error("bad pid");
  nak_retry_a: assert property (clk_en && host_mode && tok_nak && hstate_r == UECC_H_IDLE
    && !ep_r[0][`UECC_EP_NAK_NAK_RETRY_DISABLE] ##1 clk_en |=> host_retry && !desc_pid_we)
    else $error("no retry");
  ep_resv_a: assert property (ep_r[1][7:5] == 3'h0 && ep_r[0][5] == 1'b0)
    else $error("reserved stored");
  transceiver_suspend_out_a: assert property (clk_en && xc_r[7] |=> xcvr_suspend) else $error("suspend");
  pd_out_a: assert property (clk_en && !xc_r[6] |=> !weak_pulldown_enable)
    else $error("pulldown");
  host_hs_a: assert property (clk_en && host_mode |=> ans_hshk == $past(ep_r[0][0]))
    else $error("host handshake");
  base_a: assert property (wr && paddr == `UECC_OFS_BASE_TOP ##1 clk_en [*2]
    |-> desc_base_top == $past(pwdata[7:0], 2)) else $error("base");

  // ************************************************************
  // Bus and output checks
  // ************************************************************
  // Zero wait states: the slave must answer in the access phase itself
  apb_ready_a: assert property (clk_en && psel && !penable |=> pready)
    else $error("pready late");
  // An address far outside the map must be flagged, never silently accepted
  apb_unmap_a: assert property (clk_en && psel && !penable && paddr == 12'hFF0 |=> pslverr)
    else $error("unmapped not flagged");
  pd_on_a: assert property (clk_en && xc_r[6] |=> weak_pulldown_enable)
    else $error("pulldown on");
  transceiver_suspend_off_a: assert property (clk_en && !xc_r[7] |=> !xcvr_suspend)
    else $error("suspend off");
  pre_pid_a: assert property (clk_en |=> host_pre_pid == $past(host_mode & ~ep_r[0][7]))
    else $error("preamble select");
  base_mask_a: assert property (desc_base_hi_mask == 9'h000)
    else $error("base misaligned");
  host_acc_a: assert property (clk_en && host_mode |=> !ans_stall && ans_accept)
    else $error("host answer");
  ep_top_resv_a: assert property (ep_r[NUM_EP-1][7:5] == 3'h0)
    else $error("reserved stored top");
  xc_resv_a: assert property (xc_r[5:2] == 4'h0)
    else $error("reserved stored xcvr");
  // Source flag is registered once more so the consumer sees a glitch-free level
  alt_out_a: assert property (clk_en |=> clk48_use_alt == $past(use_alt))
    else $error("clock source");

  cov_stall: cover property (ans_stall);
  cov_nak_done: cover property (desc_pid_we ##1 host_done);
  cov_retry: cover property (host_retry);
  cov_setup: cover property (tok_setup && !host_mode ##1 ans_accept);
  cov_suspend: cover property (xcvr_suspend ##1 !xcvr_suspend);
endmodule : uecc_ctrl

// ===== logic/uecc_defs.svh
// Register map, field positions, reset values and timing counts of the
// endpoint and transceiver control block.
// Assumes inclusion by bare name from the design files and the bench.
`ifndef UECC_DEFS_SVH
`define UECC_DEFS_SVH

// ************************************************************
// Register byte addresses
// ************************************************************
`define UECC_OFS_BASE_TOP 12'h000
`define UECC_OFS_XCVR_CTRL 12'h004
`define UECC_OFS_HOST_EVT 12'h008
`define UECC_OFS_EP_FIRST 12'h040
`define UECC_OFS_EP_LAST 12'h07C

// ************************************************************
// Field positions
// ************************************************************
`define UECC_EP_DIRECT_LS 7
`define UECC_EP_NAK_NAK_RETRY_DISABLE 6
`define UECC_EP_SETUP_DIS 4
`define UECC_RECEIVE_ENABLE 3
`define UECC_TRANSMIT_ENABLE 2
`define UECC_EP_HALT 1
`define UECC_HANDSHAKE_ENABLE 0
`define UECC_XC_SUSPEND 7
`define UECC_XC_PULLDOWN 6

// ************************************************************
// Write masks and reset values
// ************************************************************
`define UECC_EP0_WMASK 8'hDF
`define UECC_EPN_WMASK 8'h1F
`define UECC_XC_WMASK 8'hC3
`define UECC_EP_RESET 8'h00
`define UECC_XC_RESET 8'h00
`define UECC_BASE_RESET 8'h00

// ************************************************************
// Timing
// ************************************************************
`define UECC_CLK_MHZ 25
`define UECC_PLL_SETTLE_NS 80
`define UECC_PLL_SETTLE_CYC ((`UECC_PLL_SETTLE_NS * `UECC_CLK_MHZ + 999) / 1000)

`endif

// ===== logic/uecc_pkg.sv
// Types shared by the endpoint and transceiver control block.
// Assumes nothing beyond a SystemVerilog compiler.
package uecc_pkg;

  typedef enum logic [1:0] {
    UECC_ALT_PIN = 2'h0,
    UECC_PLL_1 = 2'h1,
    UECC_PLL_2 = 2'h2,
    UECC_PLL_3 = 2'h3
  } uecc_clksrc_e;

  // Host NAK handling states
  typedef enum logic [2:0] {
    UECC_H_IDLE = 3'h1,
    UECC_H_RETRY = 3'h2,
    UECC_H_DONE = 3'h4
  } uecc_hstate_e;

  typedef logic [3:0] uecc_pid_t;

endpackage : uecc_pkg

// ===== logic/uecc_ep_decode.sv
// Per-endpoint decode of control bits into answer qualifiers.
// Assumes a registered control byte for each endpoint.
`timescale 1ns/1ns
`include "uecc_defs.svh"
module uecc_ep_decode #(
  parameter int NUM_EP = 16
) (
  // Control bytes
  input wire logic [NUM_EP*8-1:0] ep_ctrl,
  // Decoded per-endpoint answers
  output logic [NUM_EP-1:0] ep_rx_ok,
  output logic [NUM_EP-1:0] ep_tx_ok,
  output logic [NUM_EP-1:0] ep_setup_ok,
  output logic [NUM_EP-1:0] endpoint_halt,
  output logic [NUM_EP-1:0] handshake_enable
);
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++) begin : g_ep
      logic [7:0] c;
      logic en;
      assign c = ep_ctrl[g*8 +: 8];
      assign en = c[`UECC_RECEIVE_ENABLE] | c[`UECC_TRANSMIT_ENABLE];
      // Stall wins over everything but only on an enabled endpoint
      assign endpoint_halt[g] = en & c[`UECC_EP_HALT];
      assign ep_rx_ok[g] = c[`UECC_RECEIVE_ENABLE] & ~endpoint_halt[g];
      assign ep_tx_ok[g] = c[`UECC_TRANSMIT_ENABLE] & ~endpoint_halt[g];
      assign ep_setup_ok[g] = c[`UECC_RECEIVE_ENABLE] & c[`UECC_TRANSMIT_ENABLE]
        & ~c[`UECC_EP_SETUP_DIS] & ~endpoint_halt[g];
      assign handshake_enable[g] = c[`UECC_HANDSHAKE_ENABLE] & ~endpoint_halt[g];
    end
  endgenerate
endmodule : uecc_ep_decode

// ===== logic/uecc_clk_sel.sv
// Selection of the 48 MHz clock source with a settle window after a switch between alternate pin and PLL.
// Assumes both candidate clock enables are synchronous qualifiers.
`timescale 1ns/1ns
`include "uecc_defs.svh"
module uecc_clk_sel (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  // Selection
  input wire logic [1:0] src_sel,
  // Status
  output logic use_alt,
  output logic settling
);
  import uecc_pkg::*;
  localparam logic [3:0] SETTLE = 4'(`UECC_PLL_SETTLE_CYC);
  logic [1:0] last_r;
  logic [3:0] cnt_r;

  // A switch between alternate pin and any PLL restarts settle count so consumers wait for a clean clock; PLL to PLL does not
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      last_r <= 2'h0;
      cnt_r <= 4'h0;
    end else if (clk_en) begin
      last_r <= src_sel;
      if ((src_sel == 2'h0) != (last_r == 2'h0)) begin
        cnt_r <= SETTLE;
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
  assign use_alt = (last_r == UECC_ALT_PIN);
  assign settling = (cnt_r != 4'h0);
endmodule : uecc_clk_sel

// ===== tb/uecc_tok_model.sv
// Token engine stand-in that presents tokens and reports NAK or completion pulses.
// Assumes the bench calls its tasks from the clocked main sequence.
`timescale 1ns/1ns
module uecc_tok_model (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Token presentation
  output logic [3:0] tok_ep,
  output logic tok_setup,
  output logic tok_in,
  // Outcome pulses
  output logic tok_nak,
  output logic tok_end
);
  initial begin
    tok_ep = 4'h0;
    tok_setup = 1'b0;
    tok_in = 1'b0;
    tok_nak = 1'b0;
    tok_end = 1'b0;
  end

  task automatic present(input logic [3:0] ep, input logic setup, input logic in_t);
    @(posedge clock);
    tok_ep <= ep;
    tok_setup <= setup;
    tok_in <= in_t;
  endtask : present

  // One-cycle pulse; callers leave a gap so the next NAK is never closer than two cycles
  task automatic outcome(input logic nak);
    @(posedge clock);
    tok_nak <= nak;
    tok_end <= !nak;
    @(posedge clock);
    tok_nak <= 1'b0;
    tok_end <= 1'b0;
  endtask : outcome
endmodule : uecc_tok_model

// ===== tb/tb_usb_endpoint_control_config.sv
// Self-checking bench for the endpoint and transceiver control block.
// Assumes the token engine model beside it and an APB master in tasks here.
`timescale 1ns/1ns
`include "uecc_defs.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tb_usb_endpoint_control_config;
  import uecc_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, host_mode = 1'b0;
  logic [3:0] tok_ep;
  logic tok_nak, tok_end, tok_setup, tok_in, ans_stall, ans_accept, ans_hshk;
  logic host_retry, host_pre_pid, host_done, desc_pid_we;
  uecc_pid_t desc_pid;
  logic [8:0] desc_base_hi_mask;
  logic [7:0] desc_base_top;
  logic xcvr_suspend, weak_pulldown_enable, clk48_use_alt, clk48_settling;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;

  uecc_ctrl u_uecc_ctrl (.clock(clock), .arst_n(arst_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .host_mode(host_mode), .tok_ep(tok_ep),
    .tok_nak(tok_nak), .tok_end(tok_end), .tok_setup(tok_setup), .tok_in(tok_in),
    .ans_stall(ans_stall), .ans_accept(ans_accept), .ans_hshk(ans_hshk),
    .host_retry(host_retry), .host_pre_pid(host_pre_pid), .host_done(host_done),
    .desc_pid(desc_pid), .desc_pid_we(desc_pid_we), .desc_base_hi_mask(desc_base_hi_mask),
    .desc_base_top(desc_base_top), .xcvr_suspend(xcvr_suspend),
    .weak_pulldown_enable(weak_pulldown_enable), .clk48_use_alt(clk48_use_alt),
    .clk48_settling(clk48_settling));
  uecc_tok_model u_uecc_tok_model (.clock(clock), .arst_n(arst_n), .tok_ep(tok_ep),
    .tok_setup(tok_setup), .tok_in(tok_in), .tok_nak(tok_nak), .tok_end(tok_end));

  always #20 clock = ~clock;

  // ************************************************************
  // APB master and helpers
  // ************************************************************
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, {24'h0, d}, rd, err);
  endtask : wr

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    `CHK(rd, exp)
    `CHK(err, eexp)
  endtask : rdchk

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    `CHK({xcvr_suspend, weak_pulldown_enable, clk48_use_alt}, 3'b001)
    rdchk(`UECC_OFS_BASE_TOP, 32'h0, 1'b0);
    rdchk(`UECC_OFS_XCVR_CTRL, 32'h0, 1'b0);
    rdchk(12'h0F0, 32'h0, 1'b1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_base();
    wr(`UECC_OFS_BASE_TOP, 8'hA5);
    rdchk(`UECC_OFS_BASE_TOP, 32'hA5, 1'b0);
    `CHK(desc_base_top, 8'hA5)
    `CHK(desc_base_hi_mask, 9'h000)
    $display("test base done");
  endtask : t_base

  task automatic t_endpoints();
    for (int i = 0; i < 16; i++) begin
      wr(12'h040 + 12'(4 * i), 8'hFF);
    end
    // Reserved bit 5 everywhere, and the host-only bits 7..6 beyond endpoint 0
    for (int i = 0; i < 16; i++) begin
      rdchk(12'h040 + 12'(4 * i), (i == 0) ? 32'hDF : 32'h1F, 1'b0);
    end
    $display("test endpoints done");
  endtask : t_endpoints

  task automatic t_decode();
    logic [7:0] c;
    logic acc;
    for (int v = 0; v < 32; v++) begin
      c = 8'(v);
      wr(12'h05C, c);
      for (int k = 0; k < 3; k++) begin
        u_uecc_tok_model.present(4'h7, k == 2, k == 1);
        repeat (2) @(posedge clock);
        #1;
        acc = (k == 2) ? (c[3] & c[2] & !c[4]) : (k == 1) ? c[2] : c[3];
        `CHK(ans_stall, c[1] & (c[3] | c[2]))
        if (!(c[1] & (c[3] | c[2]))) begin
          `CHK(ans_accept, acc)
          `CHK(ans_hshk, c[0])
        end
      end
    end
    // A halted endpoint keeps stalling until software clears the halt bit
    wr(12'h05C, 8'h0A);
    repeat (2) begin
      u_uecc_tok_model.present(4'h7, 1'b0, 1'b0);
      repeat (3) @(posedge clock);
      #1;
      `CHK(ans_stall, 1'b1)
    end
    wr(12'h05C, 8'h08);
    repeat (2) @(posedge clock);
    #1;
    `CHK(ans_stall, 1'b0)
    $display("test decode done");
  endtask : t_decode

  task automatic t_host();
    logic [7:0] vals [3] = '{8'h4D, 8'h4C, 8'hCD};
    host_mode <= 1'b1;
    wr(12'h064, 8'h0E);
    for (int i = 0; i < 3; i++) begin
      wr(`UECC_OFS_EP_FIRST, vals[i]);
      u_uecc_tok_model.present(4'h9, 1'b0, 1'b1);
      repeat (2) @(posedge clock);
      #1;
      `CHK({ans_stall, ans_accept, ans_hshk}, {2'b01, vals[i][0]})
      `CHK(host_pre_pid, !vals[i][7])
    end
    $display("test host done");
  endtask : t_host

  task automatic watch(input logic nak, output int t_we, output int t_done, output int t_rt);
    t_we = -1;
    t_done = -1;
    t_rt = -1;
    fork
      u_uecc_tok_model.outcome(nak);
      for (int i = 0; i < 8; i++) begin
        @(posedge clock);
        #1;
        if (desc_pid_we === 1'b1) t_we = i;
        if (desc_pid_we === 1'b1) `CHK(desc_pid, 4'hA)
        if (host_done === 1'b1) t_done = i;
        if (host_retry === 1'b1) t_rt = i;
      end
    join
  endtask : watch

  task automatic t_nak();
    int we, dn, rt;
    wr(`UECC_OFS_EP_FIRST, 8'h4D);
    watch(1'b1, we, dn, rt);
    `CHK(we >= 0, 1'b1)
    `CHK(dn, we + 1)
    `CHK(rt, -1)
    wr(`UECC_OFS_EP_FIRST, 8'h0D);
    watch(1'b1, we, dn, rt);
    `CHK({we, dn}, {-32'sd1, -32'sd1})
    `CHK(rt >= 0, 1'b1)
    watch(1'b0, we, dn, rt);
    `CHK(dn >= 0 && we == -1, 1'b1)
    rdchk(`UECC_OFS_HOST_EVT, 32'h2, 1'b0);
    host_mode <= 1'b0;
    $display("test nak done");
  endtask : t_nak

  task automatic t_xcvr();
    logic [1:0] seq [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
    logic [1:0] s;
    logic prev_alt;
    int hi;
    prev_alt = 1'b1;
    for (int i = 0; i < 5; i++) begin
      s = seq[i];
      wr(`UECC_OFS_XCVR_CTRL, {s[1], s[0], 4'hF, s});
      hi = 0;
      for (int j = 0; j < 6; j++) begin
        @(posedge clock);
        #1;
        if (clk48_settling === 1'b1) hi++;
      end
      `CHK(hi, (prev_alt != (s == 2'h0)) ? 2 : 0)
      `CHK({xcvr_suspend, weak_pulldown_enable}, s)
      `CHK(clk48_use_alt, s == 2'h0)
      rdchk(`UECC_OFS_XCVR_CTRL, {24'h0, s[1], s[0], 4'h0, s}, 1'b0);
      prev_alt = (s == 2'h0);
    end
    $display("test transceiver done");
  endtask : t_xcvr

  // ************************************************************
  // Run control
  // ************************************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  // Ceiling is several times the longest expected run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      finish_test();
    end
  end

  initial begin
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    t_reset();
    t_base();
    t_endpoints();
    t_decode();
    t_host();
    t_nak();
    t_xcvr();
    finish_test();
  end
endmodule : tb_usb_endpoint_control_config
